// [logic/ov_fault_response.sv]
// overvoltage fault response sequencer with its response register
`timescale 1ns/100ps
module ov_fault_response
    import ov_resp_pkg::*;
#(
    parameter int UNIT_CYC = UNIT_CYCLES
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  ov_resp_pkg::reg_wr_s   reg_wr_i,
    input  wire logic [7:0]        reg_addr_i,
    output logic [7:0]             reg_rdata_o,
    input  wire logic              ov_fault_i,
    input  wire logic              run_cmd_i,
    input  wire logic              other_shutdown_i,
    input  wire logic              fault_clear_i,
    output logic                   output_en_o,
    output logic                   latched_off_o,
    output logic [2:0]             attempts_o
);
    import ov_resp_pkg::*;

    typedef enum logic [2:0] {
        ST_OFF, ST_RUN, ST_DELAY, ST_WAIT, ST_RESTART, ST_HOLD, ST_LATCHED
    } state_e;

    state_e                 state_r;
    state_e                 state_nxt;
    logic [7:0]             resp_reg_r;
    ov_cfg_s                cfg;
    logic [DELAY_CNT_W-1:0] units_r;
    logic [2:0]             tries_r;
    logic                   tick;
    logic                   start_delay;
    logic                   delay_done;
    logic                   stop_all;
    // restart gap counter, wide enough for 128 units of a full divider
    localparam int          GAP_W = UNIT_CNT_W + DELAY_CNT_W;
    logic [GAP_W-1:0]       since_r;

    // field split of the response register
    assign cfg.resp    = resp_reg_r[RESP_MSB:RESP_LSB];
    assign cfg.retries = resp_reg_r[RETRY_MSB:RETRY_LSB];
    assign cfg.delay   = resp_reg_r[DELAY_MSB:DELAY_LSB];

    // register write at its documented address only
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            resp_reg_r <= OV_RESP_RESET;
        end else if (reg_wr_i.wr_en && reg_wr_i.addr == OV_RESP_OFFSET) begin
            resp_reg_r <= reg_wr_i.wdata;
        end
    end

    // read data registered; other addresses read zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= (reg_addr_i == OV_RESP_OFFSET) ? resp_reg_r : 8'h00;
        end
    end

    ov_unit_tick #(
        .UNIT_CYC (UNIT_CYC)
    ) u_tick (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .restart_i (start_delay),
        .tick_o    (tick)
    );

    // stopping causes end any sequence except a latch-off, including endless retries
    assign stop_all = !run_cmd_i || other_shutdown_i;

    // a delay window begins on entry to a timed state or a restart; in the
    // shutdown response the wait after a failed attempt keeps the timer that the attempt
    // started, so its attempts start one full delay apart (needs UNIT_CYC of 3 or more)
    assign start_delay = state_nxt != state_r
        && (state_nxt == ST_DELAY || state_nxt == ST_RESTART
            || (state_nxt == ST_WAIT
                && !(state_r == ST_RUN && tries_r != 3'h0)));

    // delay ends after 2**code units
    assign delay_done = tick
        && (units_r == delay_units(cfg.delay) - DELAY_CNT_W'(1));

    // units counted on every tick, cleared when a delay window starts
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            units_r <= '0;
        end else if (start_delay) begin
            units_r <= '0;
        end else if (tick) begin
            units_r <= units_r + DELAY_CNT_W'(1);
        end
    end

    // what to do once a fault calls for the retry policy
    function automatic state_e retry_step(input logic [2:0] limit,
                                          input logic [2:0] done);
        if (limit == RETRY_NONE) begin
            retry_step = ST_LATCHED;
        end else if (limit == RETRY_FOREVER) begin
            retry_step = ST_WAIT;
        end else if (done >= limit || limit > RETRY_MAX_COUNT) begin
            retry_step = ST_LATCHED;
        end else begin
            retry_step = ST_WAIT;
        end
    endfunction : retry_step

    // next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_OFF: begin
                if (!stop_all) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (ov_fault_i) begin
                    unique case (cfg.resp)
                        RESP_IGNORE:      state_nxt = ST_RUN;
                        RESP_DELAY:       state_nxt = ST_DELAY;
                        RESP_SHUTDOWN:
                            state_nxt = retry_step(cfg.retries, tries_r);
                        RESP_WHILE_FAULT: state_nxt = ST_HOLD;
                    endcase
                end
            end
            ST_DELAY: begin
                if (!ov_fault_i) begin
                    state_nxt = ST_RUN;
                end else if (delay_done) begin
                    state_nxt = retry_step(cfg.retries, tries_r);
                end
            end
            ST_WAIT: begin
                if (delay_done) begin
                    state_nxt = ST_RESTART;
                end
            end
            ST_RESTART: begin
                // attempt restarts the output; a persisting fault retries until the retry limit is used up, then latches
                state_nxt = ST_RUN;
            end
            ST_HOLD: begin
                if (!ov_fault_i) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_LATCHED: begin
                if (fault_clear_i) begin
                    state_nxt = ST_OFF;
                end
            end
        endcase
        if (stop_all && state_r != ST_LATCHED) begin
            state_nxt = ST_OFF;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= ST_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // attempt counter; a fault-free run cycle resets it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tries_r <= '0;
        end else if (state_r == ST_OFF || state_r == ST_LATCHED) begin
            tries_r <= '0;
        end else if (state_r == ST_RESTART && tries_r != 3'h7) begin
            tries_r <= tries_r + 3'h1;
        end else if (state_r == ST_RUN && !ov_fault_i) begin
            tries_r <= '0;
        end
    end

    // output enable registered; off in every disabling state
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            output_en_o <= 1'b0;
        end else begin
            output_en_o <= (state_nxt == ST_RUN || state_nxt == ST_DELAY
                            || state_nxt == ST_RESTART);
        end
    end

    // cycles since the last restart began, for the spacing check
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            since_r <= '0;
        end else if (state_r == ST_RESTART) begin
            since_r <= GAP_W'(1);
        end else begin
            since_r <= since_r + GAP_W'(1);
        end
    end

    assign latched_off_o = (state_r == ST_LATCHED);
    assign attempts_o    = tries_r;

    a_ignore_keeps_on: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_r == ST_RUN && cfg.resp == RESP_IGNORE && !stop_all)
        |=> output_en_o) else $error("ignore mode dropped output");
    a_delay_keeps_on: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_r == ST_DELAY && state_nxt == ST_DELAY)
        |=> output_en_o) else $error("output off during delay");
    a_shutdown_now: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_r == ST_RUN && ov_fault_i && cfg.resp == RESP_SHUTDOWN)
        |=> !output_en_o) else $error("shutdown not immediate");
    a_hold_while_fault: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_r == ST_HOLD && ov_fault_i) |=> !output_en_o)
        else $error("output on during fault hold");
    a_hold_resume: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_r == ST_HOLD && !ov_fault_i && !stop_all) |=> output_en_o)
        else $error("no resume after fault");
    a_no_retry_latch: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_r == ST_RUN && ov_fault_i && cfg.resp == RESP_SHUTDOWN
         && cfg.retries == RETRY_NONE && !stop_all)
        |=> latched_off_o) else $error("zero retries did not latch");
    a_latch_stays_off: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (latched_off_o && !fault_clear_i) |=> latched_off_o && !output_en_o)
        else $error("left latch without clear");
    // a failed attempt with endless retries must go back to waiting
    a_forever_no_latch: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (cfg.retries == RETRY_FOREVER && cfg.resp == RESP_SHUTDOWN
         && state_r == ST_RUN && ov_fault_i && !stop_all)
        |=> !latched_off_o && !output_en_o)
        else $error("endless retry latched");
    a_stop_turns_off: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        stop_all |=> !output_en_o) else $error("stop left output on");
    // start to start of two attempts in one shutdown retry chain is one full delay
    a_retry_spacing: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_r == ST_RESTART && tries_r != 3'h0
         && cfg.resp == RESP_SHUTDOWN)
        |-> since_r == GAP_W'(UNIT_CYC * delay_units(cfg.delay)))
        else $error("restart spacing off");
endmodule : ov_fault_response

// [inc/ov_resp_pkg.sv]
// constants and carriers for the overvoltage fault response block
package ov_resp_pkg;
    localparam logic [7:0] OV_RESP_OFFSET   = 8'h41;
    localparam logic [7:0] OV_RESP_RESET    = 8'h80;
    localparam int         RESP_MSB         = 7;
    localparam int         RESP_LSB         = 6;
    localparam int         RETRY_MSB        = 5;
    localparam int         RETRY_LSB        = 3;
    localparam int         DELAY_MSB        = 2;
    localparam int         DELAY_LSB        = 0;
    localparam logic [1:0] RESP_IGNORE      = 2'h0;
    localparam logic [1:0] RESP_DELAY       = 2'h1;
    localparam logic [1:0] RESP_SHUTDOWN    = 2'h2;
    localparam logic [1:0] RESP_WHILE_FAULT = 2'h3;
    localparam logic [2:0] RETRY_NONE       = 3'h0;
    localparam logic [2:0] RETRY_MAX_COUNT  = 3'h4;
    localparam logic [2:0] RETRY_FOREVER    = 3'h7;
    // time unit from the separate unit register, here in nanoseconds
    localparam int         UNIT_TIME_NS     = 1000;
    localparam int         CLK_PERIOD_NS    = 4;
    localparam int         UNIT_CYCLES      =
        (UNIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         UNIT_CNT_W       = 16;
    localparam int         DELAY_CNT_W      = 8;

    typedef struct packed {
        logic       wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_wr_s;

    typedef struct packed {
        logic [1:0] resp;
        logic [2:0] retries;
        logic [2:0] delay;
    } ov_cfg_s;

    // delay code to number of time units: 1 << code
    function automatic logic [DELAY_CNT_W-1:0] delay_units(
        input logic [2:0] code);
        delay_units = DELAY_CNT_W'(1) << code;
    endfunction : delay_units
endpackage : ov_resp_pkg

// [logic/ov_unit_tick.sv]
// time-unit divider giving one-cycle enable pulses
`timescale 1ns/100ps
module ov_unit_tick
    import ov_resp_pkg::*;
#(
    parameter int UNIT_CYC = UNIT_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic restart_i,
    output logic      tick_o
);
    logic [UNIT_CNT_W-1:0] cnt_r;

    // restart aligns the first unit with the start of a delay
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= '0;
        end else if (restart_i || cnt_r == UNIT_CNT_W'(UNIT_CYC - 1)) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + UNIT_CNT_W'(1);
        end
    end

    // not gated by restart: the sequencer's restart decision reads this tick,
    // so gating it would close a combinational loop through the restart
    assign tick_o = (cnt_r == UNIT_CNT_W'(UNIT_CYC - 1));
endmodule : ov_unit_tick

// [dv/ov_host.sv]
// management bus host model writing and reading the response register
`timescale 1ns/100ps
module ov_host
    import ov_resp_pkg::*;
(
    input  wire logic            clk_i,
    output ov_resp_pkg::reg_wr_s reg_wr_o,
    output logic [7:0]           reg_addr_o,
    input  wire logic [7:0]      reg_rdata_i
);
    import ov_resp_pkg::*;
    // idle bus at time zero, nothing strobed
    initial begin
        reg_wr_o   = '0;
        reg_addr_o = 8'h00;
    end
    // strobe stays up across exactly one rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_wr_o <= '{wr_en: 1'b1, addr: a, wdata: d};
        @(negedge clk_i);
        reg_wr_o <= '0;
    endtask : wr
    // read data is registered, so it settles one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        reg_addr_o <= a;
        @(posedge clk_i);
        @(negedge clk_i);
        d = reg_rdata_i;
    endtask : rd
endmodule : ov_host

// [dv/overvoltage_fault_response_tb.sv]
// self-checking bench for the overvoltage fault response sequencer
`timescale 1ns/100ps
module overvoltage_fault_response_tb;
    import ov_resp_pkg::*;
    localparam int U = 4; // short unit keeps retry spacing quick
    logic       clk = 1'b0, rst_n, fault = 1'b0, run = 1'b1;
    logic       oth = 1'b0, fclr = 1'b0, en, lat;
    logic [7:0] rdata, addr, v;
    logic [2:0] att;
    reg_wr_s    wr;
    int         mismatches = 0, checks = 0, cycles = 0, n, gap, hi;
    always #2 clk = ~clk;
    ov_host u_ov_host (.clk_i(clk), .reg_wr_o(wr), .reg_addr_o(addr),
        .reg_rdata_i(rdata));
    ov_fault_response #(.UNIT_CYC(U)) u_ov_fault_response (
        .clk_i(clk), .rst_n_i(rst_n), .reg_wr_i(wr), .reg_addr_i(addr),
        .reg_rdata_o(rdata), .ov_fault_i(fault), .run_cmd_i(run),
        .other_shutdown_i(oth), .fault_clear_i(fclr), .output_en_o(en),
        .latched_off_o(lat), .attempts_o(att));
    task automatic wrap_up();
        if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    // hang guard, far above the sum of all scenarios
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            wrap_up();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc
    // counts output rises over k cycles, last gap and cycles spent high
    task automatic watch(input int k);
        int last;
        logic prev;
        n = 0; gap = 0; hi = 0; last = 0; prev = en;
        for (int i = 0; i < k; i++) begin
            @(negedge clk);
            if (en === 1'b1) hi++;
            if (en === 1'b1 && prev !== 1'b1) begin
                if (n > 0) gap = i - last;
                last = i;
                n++;
            end
            prev = en;
        end
    endtask : watch
    // fault gone and latch cleared, output must come back
    task automatic recover();
        fault <= 1'b0;
        cyc(1);
        fclr <= 1'b1;
        cyc(1);
        fclr <= 1'b0;
        cyc(4);
        check({7'h0, en}, 8'h01);
        check({7'h0, lat}, 8'h00);
    endtask : recover
    task automatic t_reg();
        u_ov_host.rd(OV_RESP_OFFSET, v);
        check(v, OV_RESP_RESET);
        u_ov_host.rd(8'h40, v);
        check(v, 8'h00);
        u_ov_host.wr(8'h42, 8'h3f);
        u_ov_host.rd(OV_RESP_OFFSET, v);
        check(v, OV_RESP_RESET);
        check({7'h0, en}, 8'h01);
        u_ov_host.wr(OV_RESP_OFFSET, 8'h3f);
        u_ov_host.rd(OV_RESP_OFFSET, v);
        check(v, 8'h3f);
    endtask : t_reg
    task automatic t_ignore();
        u_ov_host.wr(OV_RESP_OFFSET, 8'h00);
        fault <= 1'b1;
        watch(40);
        check(hi[7:0], 8'd40);
        fault <= 1'b0;
    endtask : t_ignore
    task automatic t_while();
        u_ov_host.wr(OV_RESP_OFFSET, 8'hc0);
        fault <= 1'b1;
        cyc(2);
        check({6'h0, lat, en}, 8'h00);
        watch(20);
        check(hi[7:0], 8'd0);
        fault <= 1'b0;
        cyc(3);
        check({6'h0, lat, en}, 8'h01);
    endtask : t_while
    task automatic t_delay();
        u_ov_host.wr(OV_RESP_OFFSET, 8'h42); // delay code 2, no retry
        fault <= 1'b1;
        watch(40);
        // 4 units of U cycles, allow unit-tick phase slack
        check({7'h0, hi >= 4 * U - 1 && hi <= 4 * U + 2}, 8'h01);
        check({6'h0, lat, en}, 8'h02);
        recover();
    endtask : t_delay
    task automatic t_retry();
        u_ov_host.wr(OV_RESP_OFFSET, 8'h91); // shutdown, 2 retries, 2 units
        fault <= 1'b1;
        cyc(2);
        check({7'h0, en}, 8'h00);
        watch(120);
        check(n[7:0], 8'd2);
        check({7'h0, gap >= 2 * U - 1 && gap <= 2 * U + 1}, 8'h01);
        check({6'h0, lat, en}, 8'h02);
        fault <= 1'b0;
        watch(15);
        check(n[7:0], 8'd0);
        recover();
        u_ov_host.wr(OV_RESP_OFFSET, 8'h80);
        fault <= 1'b1;
        watch(30);
        check({n[6:0], lat}, 8'h01);
        recover();
    endtask : t_retry
    task automatic t_forever();
        u_ov_host.wr(OV_RESP_OFFSET, 8'hb8); // endless retries, 1 unit
        fault <= 1'b1;
        watch(150);
        check({7'h0, n > 8}, 8'h01);
        check({7'h0, lat}, 8'h00);
        check({5'h0, att}, 8'h07);
        run <= 1'b0;
        cyc(2);
        watch(30);
        check({n[3:0], hi[3:0]}, 8'h00);
        run <= 1'b1;
        fault <= 1'b0;
        cyc(6);
        check({7'h0, en}, 8'h01);
        fault <= 1'b1;
        cyc(8);
        oth <= 1'b1;
        cyc(2);
        watch(30);
        check(n[7:0], 8'd0);
        oth <= 1'b0;
        recover();
    endtask : t_forever
    initial begin
        rst_n = 1'b0;
        cyc(4);
        rst_n <= 1'b1;
        cyc(3);
        t_reg();
        t_ignore();
        t_while();
        t_delay();
        t_retry();
        t_forever();
        wrap_up();
    end
endmodule : overvoltage_fault_response_tb
